// file: adq_sequencer.sv
`timescale 1ns/1ns

// Summary of operation
// - Zero latency: every conversion gets full settling, rate fixed by settling time.
// - Enabled channels are converted one after another in continuous mode.
// - Selecting a channel restarts the filter, raises ready, waits full settling.
// - Ready falls on valid result; next channel converts while result stays readable.
// - Settling is fs period times four, or three for the lower filter order.
// - Status byte follows 24-bit data when appending; low nibble names channel.
// - After any reset the interface waits for a communications byte first.
// - Communications byte picks read or write and the target register.
// - Writes enter on data input, reads leave on data-out, timed by sclk.
// - Data-out low on new word, high after data read and before update.
// - Data word may be reread; host finishes reads before next update.
// - Chip select may stay low permanently; ready still visible on data-out.
// - Output MSB appears when chip select falls; free-running sclk tolerated.
// - Forty consecutive ones on data input reset interface and all registers.
// - Opmode 0,0,1 powers up, converts once, returns to power-down.
// - Oscillator wake of about 1 ms precedes a single conversion from power-down.
// - Single mode: ready stays high after read until next conversion completes.
// - Single mode cycles each enabled channel once, ready low after each result.
// - Continuous conversion is the operating mode after power-up.
module adq_sequencer #(
	parameter int OSC_WAKE_CYC = adq_pkg::OSC_WAKE_CYC,
	parameter int FS_UNIT_CYC  = adq_pkg::FS_UNIT_CYC
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        din,
	output logic             dout_rdy,
	output logic             dout_oe,
	input  wire logic [23:0] conv_result,
	output logic             flt_restart,
	output logic [2:0]       chan_sel,
	output logic             osc_on,
	output logic             dual_mains_reject
);

	adq_pkg::adq_pins_s pins_raw;
	adq_pkg::adq_pins_s pins;
	adq_pkg::adq_seq_e  seq_state;
	adq_pkg::adq_if_e   if_state;
	adq_pkg::adq_conv_s result;

	logic        sclk_d;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_active;
	logic [5:0]  ones_cnt;
	logic        soft_rst;

	logic [23:0] mode_reg;
	logic [23:0] config_reg;
	logic        rdy_n;

	logic [5:0]  bit_cnt;
	logic [5:0]  xfer_len;
	logic [2:0]  target;
	logic [23:0] shin;
	logic [31:0] shout;
	logic [23:0] word_in;
	logic        last_bit;
	logic        wr_mode;
	logic        wr_cfg;
	logic        data_rd;

	logic        kick;
	logic [2:0]  cur_ch;
	logic        tmr_clear;
	logic        tmr_load;
	logic [25:0] tmr_value;
	logic        tmr_pre;
	logic        tmr_done;
	logic        conv_done;
	logic        seq_start;
	logic [3:0]  nxt;
	logic [3:0]  first_ch;
	logic [2:0]  opmode;
	logic [7:0]  ch_en;
	logic [9:0]  fs_val;
	logic [25:0] period_cyc;
	logic [25:0] settle_cyc;
	logic [7:0]  status;

	assign pins_raw = '{cs_n: cs_n, sclk: sclk, din: din};

	adq_sync u_sync (
		.mclk     (mclk),
		.resetn   (resetn),
		.pins_in  (pins_raw),
		.pins_out (pins)
	);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			sclk_d <= 1'b1;
		else
			sclk_d <= pins.sclk;
	end

	assign cs_active = !pins.cs_n;
	assign sclk_rise = cs_active && pins.sclk && !sclk_d;
	assign sclk_fall = cs_active && !pins.sclk && sclk_d;

	// Interface reset by a long run of ones
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			ones_cnt <= 6'h00;
		else if (soft_rst)
			ones_cnt <= 6'h00;
		else if (sclk_rise)
			ones_cnt <= pins.din ? ones_cnt + 6'h01 : 6'h00;
	end

	assign soft_rst = sclk_rise && pins.din && (ones_cnt == 6'(adq_pkg::RESET_ONES - 1));

	// Register fields
	assign opmode            = mode_reg[adq_pkg::MODE_OP_MSB:adq_pkg::MODE_OP_LSB];
	assign ch_en             = config_reg[adq_pkg::CFG_CH_MSB:adq_pkg::CFG_CH_LSB];
	assign fs_val            = (mode_reg[adq_pkg::MODE_FS_MSB:0] == 10'h000) ? 10'h001
		: mode_reg[adq_pkg::MODE_FS_MSB:0];
	assign dual_mains_reject = mode_reg[adq_pkg::MODE_REJ];
	assign status            = {rdy_n, 3'h0, result.chan};

	// Output period and settling in master clock cycles
	assign period_cyc = 26'(FS_UNIT_CYC) * 26'(fs_val);
	assign settle_cyc = mode_reg[adq_pkg::MODE_SINC3]
		? 26'(adq_pkg::SETTLE_SINC3) * period_cyc
		: 26'(adq_pkg::SETTLE_SINC4) * period_cyc;

	assign word_in  = {shin[22:0], pins.din};
	assign last_bit = (bit_cnt == xfer_len - 6'h01);
	assign wr_mode  = sclk_rise && (if_state == adq_pkg::IF_WRITE) && last_bit
		&& (target == adq_pkg::RS_MODE);
	assign wr_cfg   = sclk_rise && (if_state == adq_pkg::IF_WRITE) && last_bit
		&& (target == adq_pkg::RS_CONFIG);
	assign data_rd  = sclk_rise && (if_state == adq_pkg::IF_READ) && last_bit
		&& (target == adq_pkg::RS_DATA);

	// Left-aligned read image of a register
	function automatic logic [31:0] read_image(input logic [2:0] rs);
		logic [31:0] img;
		case (rs)
			adq_pkg::RS_COMMS:  img = {status, 24'h000000};
			adq_pkg::RS_MODE:   img = {mode_reg, 8'h00};
			adq_pkg::RS_CONFIG: img = {config_reg, 8'h00};
			adq_pkg::RS_DATA:   img = {result.data, mode_reg[adq_pkg::MODE_STA] ? status : 8'h00};
			default:            img = 32'h00000000;
		endcase
		return img;
	endfunction : read_image

	function automatic logic [5:0] read_len(input logic [2:0] rs);
		logic [5:0] len;
		case (rs)
			adq_pkg::RS_COMMS: len = adq_pkg::LEN_BYTE;
			adq_pkg::RS_DATA:  len = mode_reg[adq_pkg::MODE_STA] ? adq_pkg::LEN_WORD_STA
				: adq_pkg::LEN_WORD;
			default:           len = adq_pkg::LEN_WORD;
		endcase
		return len;
	endfunction : read_len

	// Serial interface: every access opens with a communications byte
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			if_state <= adq_pkg::IF_COMMS;
			bit_cnt  <= 6'h00;
			xfer_len <= adq_pkg::LEN_BYTE;
			target   <= adq_pkg::RS_COMMS;
			shin     <= 24'h000000;
			shout    <= 32'h00000000;
		end else if (soft_rst) begin
			if_state <= adq_pkg::IF_COMMS;
			bit_cnt  <= 6'h00;
			xfer_len <= adq_pkg::LEN_BYTE;
			target   <= adq_pkg::RS_COMMS;
			shin     <= 24'h000000;
			shout    <= 32'h00000000;
		end else if (!cs_active) begin
			// Deselect drops any partial word but keeps the pending operation
			bit_cnt <= 6'h00;
		end else if (sclk_rise) begin
			shin <= word_in;
			if (!last_bit) begin
				bit_cnt <= bit_cnt + 6'h01;
			end else begin
				bit_cnt <= 6'h00;
				case (if_state)
					adq_pkg::IF_COMMS: begin
						target <= word_in[adq_pkg::COMMS_RS_MSB:adq_pkg::COMMS_RS_LSB];
						if (word_in[adq_pkg::COMMS_RW]) begin
							if_state <= adq_pkg::IF_READ;
							xfer_len <= read_len(word_in[adq_pkg::COMMS_RS_MSB:adq_pkg::COMMS_RS_LSB]);
							shout    <= read_image(word_in[adq_pkg::COMMS_RS_MSB:adq_pkg::COMMS_RS_LSB]);
						end else if (word_in[adq_pkg::COMMS_RS_MSB:adq_pkg::COMMS_RS_LSB]
							== adq_pkg::RS_MODE
							|| word_in[adq_pkg::COMMS_RS_MSB:adq_pkg::COMMS_RS_LSB]
							== adq_pkg::RS_CONFIG) begin
							if_state <= adq_pkg::IF_WRITE;
							xfer_len <= adq_pkg::LEN_WORD;
						end
					end
					adq_pkg::IF_WRITE,
					adq_pkg::IF_READ: begin
						if_state <= adq_pkg::IF_COMMS;
						xfer_len <= adq_pkg::LEN_BYTE;
					end
					default: begin
						if_state <= adq_pkg::IF_COMMS;
						xfer_len <= adq_pkg::LEN_BYTE;
					end
				endcase
			end
		end else if (sclk_fall && if_state == adq_pkg::IF_READ && bit_cnt != 6'h00) begin
			shout <= {shout[30:0], 1'b0};
		end
	end

	// Data-out shows the shifter during a read and ready otherwise
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dout_rdy <= 1'b1;
			dout_oe  <= 1'b0;
		end else begin
			dout_oe  <= cs_active;
			dout_rdy <= (if_state == adq_pkg::IF_READ) ? shout[31] : rdy_n;
		end
	end

	// Configuration registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_reg   <= adq_pkg::MODE_RESET;
			config_reg <= adq_pkg::CONFIG_RESET;
		end else if (soft_rst) begin
			mode_reg   <= adq_pkg::MODE_RESET;
			config_reg <= adq_pkg::CONFIG_RESET;
		end else begin
			if (wr_mode)
				mode_reg <= word_in;
			if (wr_cfg)
				config_reg <= word_in;
		end
	end

	// Conversion sequencer
	assign first_ch  = adq_pkg::adq_next_chan(ch_en, 3'h7);
	assign nxt       = adq_pkg::adq_next_chan(ch_en, cur_ch);
	// A restart in the same cycle discards the expiring conversion
	assign conv_done = tmr_done && !seq_start
		&& (seq_state == adq_pkg::SQ_SETTLE || seq_state == adq_pkg::SQ_RUN);
	assign seq_start = kick;

	always_comb begin
		tmr_clear = 1'b0;
		tmr_load  = 1'b0;
		tmr_value = settle_cyc;
		if (seq_start) begin
			if (first_ch[3] || (opmode != adq_pkg::OP_CONT && opmode != adq_pkg::OP_SINGLE)) begin
				tmr_clear = 1'b1;
			end else if (opmode == adq_pkg::OP_SINGLE && seq_state == adq_pkg::SQ_IDLE) begin
				tmr_load  = 1'b1;
				tmr_value = 26'(OSC_WAKE_CYC);
			end else begin
				tmr_load = 1'b1;
			end
		end else if (tmr_done && seq_state == adq_pkg::SQ_WAKE) begin
			tmr_load = 1'b1;
		end else if (conv_done) begin
			if (opmode == adq_pkg::OP_SINGLE && nxt[2:0] <= cur_ch) begin
				tmr_clear = 1'b1;
			end else if (nxt[2:0] != cur_ch || mode_reg[adq_pkg::MODE_ZLAT]) begin
				tmr_load = 1'b1;
			end else begin
				tmr_load  = 1'b1;
				tmr_value = period_cyc;
			end
		end
	end

	adq_timer u_timer (
		.mclk     (mclk),
		.resetn   (resetn),
		.clear    (tmr_clear),
		.load     (tmr_load),
		.value    (tmr_value),
		.pre_done (tmr_pre),
		.done     (tmr_done)
	);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			seq_state   <= adq_pkg::SQ_IDLE;
			kick        <= 1'b1;
			cur_ch      <= 3'h0;
			flt_restart <= 1'b0;
		end else if (soft_rst) begin
			seq_state   <= adq_pkg::SQ_IDLE;
			kick        <= 1'b1;
			cur_ch      <= 3'h0;
			flt_restart <= 1'b0;
		end else begin
			// Restart one cycle after a write so it acts on the new register values
			kick        <= wr_mode || wr_cfg;
			flt_restart <= 1'b0;
			if (seq_start) begin
				if (tmr_clear) begin
					seq_state <= adq_pkg::SQ_IDLE;
				end else if (tmr_value == settle_cyc && seq_state != adq_pkg::SQ_IDLE
					|| opmode == adq_pkg::OP_CONT) begin
					seq_state   <= adq_pkg::SQ_SETTLE;
					cur_ch      <= first_ch[2:0];
					flt_restart <= 1'b1;
				end else begin
					seq_state <= adq_pkg::SQ_WAKE;
				end
			end else begin
				case (seq_state)
					adq_pkg::SQ_WAKE: begin
						if (tmr_done) begin
							seq_state   <= adq_pkg::SQ_SETTLE;
							cur_ch      <= first_ch[2:0];
							flt_restart <= 1'b1;
						end
					end
					adq_pkg::SQ_SETTLE,
					adq_pkg::SQ_RUN: begin
						if (conv_done) begin
							if (tmr_clear) begin
								seq_state <= adq_pkg::SQ_IDLE;
							end else if (tmr_value == settle_cyc) begin
								seq_state   <= adq_pkg::SQ_SETTLE;
								cur_ch      <= nxt[2:0];
								flt_restart <= 1'b1;
							end else begin
								seq_state <= adq_pkg::SQ_RUN;
							end
						end
					end
					adq_pkg::SQ_IDLE: seq_state <= adq_pkg::SQ_IDLE;
					default:          seq_state <= adq_pkg::SQ_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			chan_sel <= 3'h0;
			osc_on   <= 1'b1;
		end else begin
			chan_sel <= cur_ch;
			// Up no later than the first restart out of power-down
			osc_on   <= (seq_state != adq_pkg::SQ_IDLE) || (seq_start && !tmr_clear);
		end
	end

	// Result capture; the read shifter holds its own copy
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			result <= '0;
		else if (soft_rst)
			result <= '0;
		else if (conv_done)
			result <= '{chan: {1'b0, cur_ch}, data: conv_result};
	end

	// Ready: a fresh result wins over a read finishing in the same cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			rdy_n <= 1'b1;
		else if (soft_rst)
			rdy_n <= 1'b1;
		else if (conv_done)
			rdy_n <= 1'b0;
		else if (seq_start || data_rd)
			rdy_n <= 1'b1;
		else if (tmr_pre && (seq_state == adq_pkg::SQ_SETTLE || seq_state == adq_pkg::SQ_RUN))
			rdy_n <= 1'b1;
	end

endmodule : adq_sequencer

// file: adq_pkg.sv
package adq_pkg;

	// Clock and timing
	localparam int CLK_MHZ      = 10;
	localparam int OSC_WAKE_US  = 1000;
	localparam int OSC_WAKE_CYC = OSC_WAKE_US * CLK_MHZ;
	localparam int FS_UNIT_CYC  = 1024;
	localparam int SETTLE_SINC4 = 4;
	localparam int SETTLE_SINC3 = 3;
	localparam int RESET_ONES   = 40;

	// Register selects carried in the communications byte
	localparam logic [2:0] RS_COMMS  = 3'h0;
	localparam logic [2:0] RS_MODE   = 3'h1;
	localparam logic [2:0] RS_CONFIG = 3'h2;
	localparam logic [2:0] RS_DATA   = 3'h3;

	// Communications byte fields
	localparam int COMMS_RW     = 6;
	localparam int COMMS_RS_MSB = 5;
	localparam int COMMS_RS_LSB = 3;

	// Mode register fields
	localparam int MODE_OP_MSB  = 23;
	localparam int MODE_OP_LSB  = 21;
	localparam int MODE_STA     = 20;
	localparam int MODE_SINC3   = 15;
	localparam int MODE_ZLAT    = 11;
	localparam int MODE_REJ     = 10;
	localparam int MODE_FS_MSB  = 9;

	// Configuration register fields
	localparam int CFG_CH_MSB   = 15;
	localparam int CFG_CH_LSB   = 8;

	// Values after reset
	localparam logic [23:0] MODE_RESET   = 24'h080060;
	localparam logic [23:0] CONFIG_RESET = 24'h000100;

	localparam logic [2:0] OP_CONT   = 3'h0;
	localparam logic [2:0] OP_SINGLE = 3'h1;

	// Transfer lengths in bits
	localparam logic [5:0] LEN_BYTE     = 6'h08;
	localparam logic [5:0] LEN_WORD     = 6'h18;
	localparam logic [5:0] LEN_WORD_STA = 6'h20;

	typedef enum logic [1:0] {
		SQ_IDLE   = 2'h0,
		SQ_WAKE   = 2'h1,
		SQ_SETTLE = 2'h3,
		SQ_RUN    = 2'h2
	} adq_seq_e;

	typedef enum logic [1:0] {
		IF_COMMS = 2'h0,
		IF_WRITE = 2'h1,
		IF_READ  = 2'h3
	} adq_if_e;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} adq_pins_s;

	typedef struct packed {
		logic [3:0]  chan;
		logic [23:0] data;
	} adq_conv_s;

	localparam adq_pins_s PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};

	// Next enabled channel after cur, wrapping; index 8 when none enabled
	function automatic logic [3:0] adq_next_chan(input logic [7:0] en, input logic [2:0] cur);
		logic [3:0] res;
		logic [2:0] idx;
		res = 4'h8;
		for (int k = 8; k >= 1; k--) begin
			idx = cur + 3'(k);
			if (en[idx])
				res = {1'b0, idx};
		end
		return res;
	endfunction : adq_next_chan

endpackage : adq_pkg

// file: adq_sync.sv
`timescale 1ns/1ns

module adq_sync (
	input  wire logic          mclk,
	input  wire logic          resetn,
	input  adq_pkg::adq_pins_s pins_in,
	output adq_pkg::adq_pins_s pins_out
);

	adq_pkg::adq_pins_s stage;

	// First stage feeds only the second
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stage    <= adq_pkg::PINS_IDLE;
			pins_out <= adq_pkg::PINS_IDLE;
		end else begin
			stage    <= pins_in;
			pins_out <= stage;
		end
	end

endmodule : adq_sync

// file: adq_timer.sv
`timescale 1ns/1ns

module adq_timer (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        clear,
	input  wire logic        load,
	input  wire logic [25:0] value,
	output logic             pre_done,
	output logic             done
);

	logic [25:0] count;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			count <= 26'h0000000;
		else if (clear)
			count <= 26'h0000000;
		else if (load)
			count <= value;
		else if (count != 26'h0000000)
			count <= count - 26'h0000001;
	end

	// Warning one cycle ahead lets ready rise before the update
	// Not gated by load: the reload decision reads done, a gate would close a loop
	assign pre_done = (count == 26'h0000002);
	assign done     = (count == 26'h0000001);

endmodule : adq_timer

// file: adq_sequencer_checker.sv
`timescale 1ns/1ns

module adq_sequencer_checker #(
	parameter int OSC_WAKE_CYC = 50,
	parameter int FS_UNIT_CYC  = 4
) (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic        din,
	input wire logic        dout_rdy,
	input wire logic        dout_oe,
	input wire logic [23:0] conv_result,
	input wire logic        flt_restart,
	input wire logic [2:0]  chan_sel,
	input wire logic        osc_on,
	input wire logic        dual_mains_reject
);
	logic       sclk_q;
	logic [5:0] ones;
	logic [3:0] quiet;

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Quiet count keeps shifted data bits apart from true ready edges
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sclk_q <= 1'b1;
			quiet  <= 4'h0;
		end else begin
			sclk_q <= sclk;
			quiet  <= (sclk != sclk_q) ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			ones <= 6'h00;
		else if (cs_n)
			ones <= 6'h00;
		else if (sclk && !sclk_q)
			ones <= din ? ((ones == 6'h3F) ? ones : ones + 6'h01) : 6'h00;
	end

	sequence s_ones_hit;
		$rose(ones == 6'h28);
	endsequence

	sequence s_restart_low;
		flt_restart && chan_sel == 3'h0;
	endsequence

	a_oe_select: assert property (!cs_n [*6] |-> dout_oe)
		else $error("output enable missing while selected");
	a_oe_release: assert property (cs_n [*6] |-> !dout_oe)
		else $error("output enable left on while deselected");
	a_restart_pulse: assert property (flt_restart |=> !flt_restart)
		else $error("filter restart longer than one cycle");
	a_chan_restart: assert property ($changed(chan_sel) |-> (##[0:4] flt_restart) or $past(flt_restart))
		else $error("channel changed without filter restart");
	a_soft_reset: assert property (s_ones_hit |-> ##[1:12] s_restart_low)
		else $error("forty ones did not restart on lowest channel");
	a_down_no_restart: assert property (!osc_on |-> !flt_restart)
		else $error("restart while powered down");
	a_down_chan_hold: assert property (!osc_on && !$past(osc_on) |-> $stable(chan_sel))
		else $error("channel moved while powered down");
	a_down_rdy_quiet: assert property (!osc_on && !$past(osc_on) && !cs_n && quiet == 4'hF |-> !$fell(dout_rdy))
		else $error("ready fell while powered down");
endmodule : adq_sequencer_checker

bind adq_sequencer adq_sequencer_checker #(
	.OSC_WAKE_CYC(OSC_WAKE_CYC),
	.FS_UNIT_CYC (FS_UNIT_CYC)
) adq_sequencer_checker_inst (
	.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din),
	.dout_rdy(dout_rdy), .dout_oe(dout_oe), .conv_result(conv_result),
	.flt_restart(flt_restart), .chan_sel(chan_sel), .osc_on(osc_on),
	.dual_mains_reject(dual_mains_reject)
);

// file: adq_host_model.sv
`timescale 1ns/1ns

module adq_host_model (
	input  wire logic mclk,
	input  wire logic dout_rdy,
	input  wire logic dout_oe,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din  = 1'b0;
	end

	// Bits are sampled late in the high phase, where the shifted bit has settled
	task automatic xfer(input int n, input logic [39:0] w, output logic [39:0] r);
		r = '0;
		if (cs_n) begin
			cs_n = 1'b0;
			repeat (4) @(negedge mclk);
		end
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge mclk);
			sclk = 1'b0;
			din  = w[i];
			repeat (4) @(negedge mclk);
			sclk = 1'b1;
			repeat (3) @(negedge mclk);
			// Undriven line reads inverted, so a late enable shows up
			r[i] = dout_oe ? dout_rdy : ~dout_rdy;
		end
		// Stale once the frame ends
		din = ~din;
	endtask : xfer

	task automatic deselect;
		cs_n = 1'b1;
		repeat (10) @(negedge mclk);
	endtask : deselect
endmodule : adq_host_model

// file: test_adc_serial_sequencer.sv
`timescale 1ns/1ns

module test_adc_serial_sequencer;
	typedef struct packed {
		logic [23:0] cfg;
		logic [23:0] mode;
		logic [23:0] res;
		logic [2:0]  chan;
		logic        rej;
		logic [11:0] settle;
	} adq_row_s;

	logic        mclk;
	logic        resetn;
	logic        cs_n;
	logic        sclk;
	logic        din;
	logic        dout_rdy;
	logic        dout_oe;
	logic [23:0] conv_result;
	logic        flt_restart;
	logic [2:0]  chan_sel;
	logic        osc_on;
	logic        dual_mains_reject;
	logic [39:0] rd;
	int          failures = 0;
	int          samples_checked = 0;
	int          waited;
	int          cyc = 0;
	int          t_first;
	int          restarts = 0;
	int          r0;
	adq_row_s    rows [4];

	adq_sequencer #(.OSC_WAKE_CYC(50), .FS_UNIT_CYC(4)) adq_sequencer_inst (
		.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout_rdy(dout_rdy), .dout_oe(dout_oe), .conv_result(conv_result),
		.flt_restart(flt_restart), .chan_sel(chan_sel), .osc_on(osc_on),
		.dual_mains_reject(dual_mains_reject)
	);

	adq_host_model adq_host_model_inst (
		.mclk(mclk), .dout_rdy(dout_rdy), .dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk),
		.din(din)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk)
		cyc <= cyc + 1;

	always @(posedge mclk)
		if (flt_restart)
			restarts <= restarts + 1;

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Every access is a command byte followed by the selected transfer
	task automatic comms(input logic [7:0] c, input int n, input logic [39:0] w);
		adq_host_model_inst.xfer(8, {32'h0, c}, rd);
		adq_host_model_inst.xfer(n, w, rd);
	endtask : comms

	task automatic wait_ready(input int lim);
		waited = 0;
		while (dout_rdy !== 1'b0 && waited < lim) begin
			@(negedge mclk);
			waited++;
		end
		check("ready wait", 1, waited < lim);
	endtask : wait_ready

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	initial begin
		#6000000;
		failures++;
		$display("mismatch watchdog expected finish seen hang");
		complete_run();
	end

	initial begin
		resetn      = 1'b0;
		conv_result = 24'h000000;
		rows[0] = '{24'h000100, 24'h100880, 24'hA5C30F, 3'h0, 1'b0, 12'h800};
		rows[1] = '{24'h000800, 24'h100C80, 24'h5A3CF0, 3'h3, 1'b1, 12'h800};
		rows[2] = '{24'h008000, 24'h108880, 24'hFFFFFF, 3'h7, 1'b0, 12'h600};
		rows[3] = '{24'h002000, 24'h100080, 24'h000001, 3'h5, 1'b0, 12'h800};
		repeat (3) @(negedge mclk);
		check("reset ready", 1, dout_rdy);
		check("reset oe", 0, dout_oe);
		check("reset osc", 1, osc_on);
		check("reset chan", 0, chan_sel);
		$display("reset test done");
		repeat (3) @(negedge mclk);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		foreach (rows[i]) begin
			comms(8'h10, 24, {16'h0, rows[i].cfg});
			comms(8'h08, 24, {16'h0, rows[i].mode});
			conv_result = rows[i].res;
			wait_ready(4000);
			check("settle", 1, waited >= rows[i].settle - 4 && waited <= rows[i].settle + 12);
			check("channel", rows[i].chan, chan_sel);
			comms(8'h58, 32, 40'h0);
			check("data word", rows[i].res, rd[31:8]);
			check("status", {5'h00, rows[i].chan}, rd[7:0]);
			check("mains reject", rows[i].rej, dual_mains_reject);
			repeat (8) @(negedge mclk);
			check("ready after read", 1, dout_rdy);
			$display("row %0d done", i);
		end
		comms(8'h10, 24, 40'h000600);
		comms(8'h08, 24, 40'h100080);
		conv_result = 24'h13579B;
		wait_ready(4000);
		t_first = cyc;
		r0 = restarts;
		comms(8'h58, 32, 40'h0);
		check("first word", 32'h13579B01, rd[31:0]);
		conv_result = 24'h2468AC;
		wait_ready(4000);
		check("sweep step", 1, cyc - t_first >= 2040 && cyc - t_first <= 2060);
		check("restarts per step", 1, restarts - r0);
		comms(8'h58, 32, 40'h0);
		check("second word", 32'h2468AC02, rd[31:0]);
		$display("multichannel test done");
		comms(8'h08, 24, 40'h400080);
		repeat (20) @(negedge mclk);
		check("idle osc", 0, osc_on);
		comms(8'h08, 24, 40'h300080);
		conv_result = 24'hC0FFEE;
		wait_ready(4000);
		check("wake and settle", 1, waited >= 2094 && waited <= 2116);
		comms(8'h58, 32, 40'h0);
		check("single first", 32'hC0FFEE01, rd[31:0]);
		conv_result = 24'h0BEEF0;
		wait_ready(4000);
		comms(8'h58, 32, 40'h0);
		check("single second", 32'h0BEEF002, rd[31:0]);
		repeat (20) @(negedge mclk);
		check("power down", 0, osc_on);
		t_first = cyc;
		while (cyc - t_first < 3000 && dout_rdy === 1'b1)
			@(negedge mclk);
		check("ready held", 1, dout_rdy);
		adq_host_model_inst.xfer(8, 40'h58, rd);
		adq_host_model_inst.deselect();
		check("oe released", 0, dout_oe);
		adq_host_model_inst.xfer(32, 40'h0, rd);
		check("reread", 32'h0BEEF082, rd[31:0]);
		$display("single conversion test done");
		adq_host_model_inst.xfer(40, 40'hFF_FFFF_FFFF, rd);
		repeat (5000) @(negedge mclk);
		check("osc back", 1, osc_on);
		adq_host_model_inst.xfer(8, 40'h18, rd);
		comms(8'h48, 24, 40'h0);
		check("mode reset", 24'h080060, rd[23:0]);
		comms(8'h50, 24, 40'h0);
		check("config reset", 24'h000100, rd[23:0]);
		check("reject reset", 0, dual_mains_reject);
		$display("interface reset test done");
		complete_run();
	end
endmodule : test_adc_serial_sequencer
